// >>> brownout_and_reset_timers.sv
// Brown-out control, reset status flags and the start-up delay chain
//
// Contract
// - Mode 00 disables brown-out entirely
// - Long low supply resets until supply recovers
// - Power-up delay runs after brown-out recovery
// - Dip during power-up delay restarts it
// - Brown-out and power-up delay configured separately
// - Mode 01: software bit switches detection
// - Software bit reads zero outside mode 01
// - Trip level comes only from configuration
// - Brown-out flag cleared on brown-out, and on power-on only while detection is enabled
// - Mode 10: detection off only in sleep
// - Mode 11: detection always on
// - Power-up delay counts 2048 RC periods
// - Active-low configuration bit enables power-up delay
// - Start-up timer counts 1024 oscillator edges
// - Start-up timer only crystal modes, power-on, wake
// - PLL lock delay follows start-up delay
// - Order: power-on clear, power-up, start-up
// - RC mode without power-up delay: none
// - Delays run under held reset pin
// - Power-up delay nominally 65.5 ms
// - Power-on flag cleared only by power-on; the code also clears it on a software write of zero to the control register
`timescale 1ns/1ns
`default_nettype none
module brownout_and_reset_timers
   import reset_timers_pkg::*;
#(
   parameter int PllLockCycles = PLL_LOCK_CYCLES
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic supplyBelowTrip,
   input wire logic powerOnPulse,
   input wire logic externalResetPin_n,
   input wire logic internalRcClock,
   input wire logic oscillatorInput,
   input wire logic sleepMode,
   input wire logic wakeFromManaged,
   input wire logic [1:0] brownoutModeSelect,
   input wire logic [1:0] brownoutThresholdSelect,
   input wire logic powerupTimerOff_n,
   input wire logic [1:0] oscMode,
   input wire logic pllEnable,
   output logic [1:0] brownoutTripVoltage,
   output logic brownoutDetectOn,
   output logic internalReset,
   output logic clockStable
);
   localparam int BELOW_W = $clog2(BROWNOUT_MIN_CYCLES + 1);

   logic [4:0] syncLevel, syncRise;
   logic belowSync, porLevel, pinLow, rcRise, oscRise;
   logic brownoutEnabled, brownoutTrip, crystalMode, pllOn, powerupOn;
   logic [BELOW_W-1:0] belowCnt_ff, nxt_belowCnt;
   seq_state_t state_ff, nxt_state;
   logic fromPor_ff, nxt_fromPor;
   logic wake_ff, nxt_wake;
   logic internalReset_ff, nxt_internalReset;
   logic clockStable_ff, nxt_clockStable;
   logic softEn_ff, nxt_softEn;
   logic porFlag_ff, nxt_porFlag;
   logic brownoutFlag_ff, nxt_brownoutFlag;
   logic [1:0] tripSel_ff, nxt_tripSel;
   logic detectOn_ff, nxt_detectOn;
   logic [31:0] prdata_ff, nxt_prdata;
   logic ctrlWrite;
   logic [31:0] readValue;

   timer_if #(.W(POWERUP_WIDTH)) powerupIf ();
   timer_if #(.W(STARTUP_WIDTH)) startupIf ();
   timer_if #(.W(PLL_WIDTH)) pllIf ();
   input_sync #(.N(5)) syncInputs
   (
      .clock(clock),
      .reset_n(reset_n),
      .async({supplyBelowTrip, !powerOnPulse, externalResetPin_n,
         internalRcClock, oscillatorInput}),
      .level(syncLevel),
      .rise(syncRise)
   );
   assign belowSync = syncLevel[4];
   // Cleared synchroniser flops read as power-on and pin low, so reset holds until they settle
   assign porLevel = !syncLevel[3];
   assign pinLow = !syncLevel[2];
   assign rcRise = syncRise[1];
   assign oscRise = syncRise[0];

   assign crystalMode = (oscMode == OSC_CRYSTAL) || (oscMode == OSC_FAST_CRYSTAL);
   assign pllOn = pllEnable && (oscMode != OSC_RC);
   // Read apart from the brown-out mode on purpose
   assign powerupOn = !powerupTimerOff_n;

   always_comb
   begin
      brownoutEnabled = 1'b0;
      unique case (brownoutModeSelect)
         BROWNOUT_OFF: brownoutEnabled = 1'b0;
         BROWNOUT_SOFT: brownoutEnabled = softEn_ff;
         BROWNOUT_AWAKE: brownoutEnabled = !sleepMode;
         BROWNOUT_ALWAYS: brownoutEnabled = 1'b1;
      endcase
   end

   // Brown-out qualification: the supply must stay low past the minimum time
   always_comb
   begin
      nxt_belowCnt = '0;
      if (brownoutEnabled && belowSync)
      begin
         if (belowCnt_ff == BELOW_W'(BROWNOUT_MIN_CYCLES))
            nxt_belowCnt = belowCnt_ff;
         else
            nxt_belowCnt = BELOW_W'(belowCnt_ff + 1'b1);
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         belowCnt_ff <= '0;
      else
         belowCnt_ff <= nxt_belowCnt;
   end

   assign brownoutTrip = brownoutEnabled && belowSync &&
                         (belowCnt_ff == BELOW_W'(BROWNOUT_MIN_CYCLES));

   function automatic seq_state_t afterPowerup(input logic startupDue);
      seq_state_t s;
      s = sRun;
      if (startupDue && crystalMode)
         s = sOscStart;
      else if (startupDue && pllOn)
         s = sPllLock;
      return s;
   endfunction
   function automatic seq_state_t afterStartup();
      return pllOn ? sPllLock : sRun;
   endfunction

   // Sequencer: power-on and brown-out override every state
   always_comb
   begin
      nxt_state = state_ff;
      nxt_fromPor = fromPor_ff;
      nxt_wake = wake_ff;
      if (porLevel)
      begin
         nxt_state = sPowerOn;
         nxt_fromPor = 1'b1;
         nxt_wake = 1'b0;
      end
      else if (brownoutTrip)
      begin
         nxt_state = sBrownout;
         nxt_fromPor = 1'b0;
         nxt_wake = 1'b0;
      end
      else
      begin
         unique case (state_ff)
            sPowerOn: nxt_state = powerupOn ? sPowerup : afterPowerup(1'b1);
            sBrownout: nxt_state = powerupOn ? sPowerup : afterPowerup(fromPor_ff);
            sPowerup:
               if (powerupIf.done)
                  nxt_state = afterPowerup(fromPor_ff | wake_ff);
            sOscStart:
               if (startupIf.done)
                  nxt_state = afterStartup();
            sPllLock:
               if (pllIf.done)
                  nxt_state = sRun;
            sRun:
            begin
               nxt_wake = 1'b0;
               if (wakeFromManaged && (crystalMode || pllOn))
               begin
                  nxt_wake = 1'b1;
                  nxt_state = afterPowerup(1'b1);
               end
            end
         endcase
      end
      // A wake-up restart waits for the clock but does not reset the core
      nxt_internalReset = ((state_ff != sRun) && !wake_ff) || pinLow;
      nxt_clockStable = (state_ff == sRun);
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff <= sPowerOn;
         fromPor_ff <= 1'b1;
         wake_ff <= 1'b0;
         internalReset_ff <= 1'b1;
         clockStable_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         fromPor_ff <= nxt_fromPor;
         wake_ff <= nxt_wake;
         internalReset_ff <= nxt_internalReset;
         clockStable_ff <= nxt_clockStable;
      end
   end

   // Timers are held clear outside their own state, so any exit restarts them
   assign powerupIf.clear = (state_ff != sPowerup);
   assign powerupIf.run = (state_ff == sPowerup);
   assign powerupIf.tick = rcRise;
   assign powerupIf.lastCount = POWERUP_WIDTH'(POWERUP_TICKS - 1);
   assign startupIf.clear = (state_ff != sOscStart);
   assign startupIf.run = (state_ff == sOscStart);
   assign startupIf.tick = oscRise;
   assign startupIf.lastCount = STARTUP_WIDTH'(STARTUP_TICKS - 1);
   assign pllIf.clear = (state_ff != sPllLock);
   assign pllIf.run = (state_ff == sPllLock);
   assign pllIf.tick = 1'b1;
   assign pllIf.lastCount = PLL_WIDTH'(PllLockCycles - 1);

   tick_timer #(.W(POWERUP_WIDTH)) powerupTimer
   (
      .clock(clock),
      .reset_n(reset_n),
      .tmr(powerupIf)
   );
   tick_timer #(.W(STARTUP_WIDTH)) oscillatorStartupTimer
   (
      .clock(clock),
      .reset_n(reset_n),
      .tmr(startupIf)
   );
   tick_timer #(.W(PLL_WIDTH)) pllLockDelay
   (
      .clock(clock),
      .reset_n(reset_n),
      .tmr(pllIf)
   );

   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      return (a == RESET_CONTROL_OFFSET) || (a == STATUS_OFFSET);
   endfunction

   assign ctrlWrite = psel && penable && pwrite && (paddr == RESET_CONTROL_OFFSET);

   always_comb
   begin
      readValue = '0;
      if (paddr == RESET_CONTROL_OFFSET)
      begin
         readValue[SOFT_BROWNOUT_BIT] = (brownoutModeSelect == BROWNOUT_SOFT) && softEn_ff;
         readValue[POWERON_FLAG_BIT] = porFlag_ff;
         readValue[BROWNOUT_FLAG_BIT] = brownoutFlag_ff;
      end
      else if (paddr == STATUS_OFFSET)
      begin
         readValue[STATUS_RESET_BIT] = internalReset_ff;
         readValue[STATUS_DETECT_BIT] = brownoutEnabled;
         readValue[STATUS_POWERUP_BIT] = powerupIf.busy;
         readValue[STATUS_STARTUP_BIT] = startupIf.busy;
         readValue[STATUS_PLL_BIT] = pllIf.busy;
         readValue[STATUS_STABLE_BIT] = clockStable_ff;
      end
   end

   // Register file; hardware clears beat a software write in the same cycle
   always_comb
   begin
      nxt_softEn = softEn_ff;
      nxt_porFlag = porFlag_ff;
      nxt_brownoutFlag = brownoutFlag_ff;
      nxt_prdata = prdata_ff;
      if (ctrlWrite)
      begin
         nxt_softEn = pwdata[SOFT_BROWNOUT_BIT];
         nxt_porFlag = pwdata[POWERON_FLAG_BIT];
         nxt_brownoutFlag = pwdata[BROWNOUT_FLAG_BIT];
      end
      if (porLevel)
      begin
         nxt_softEn = SOFT_BROWNOUT_RESET;
         nxt_porFlag = 1'b0;
      end
      if (brownoutEnabled && (porLevel || brownoutTrip))
         nxt_brownoutFlag = 1'b0;
      if (psel && !penable && !pwrite)
         nxt_prdata = readValue;
      // Trip select is copied from configuration only; software has no path to it
      nxt_tripSel = brownoutThresholdSelect;
      nxt_detectOn = brownoutEnabled;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         softEn_ff <= SOFT_BROWNOUT_RESET;
         porFlag_ff <= POWERON_FLAG_RESET;
         brownoutFlag_ff <= BROWNOUT_FLAG_RESET;
         prdata_ff <= '0;
         tripSel_ff <= '0;
         detectOn_ff <= 1'b0;
      end
      else
      begin
         softEn_ff <= nxt_softEn;
         porFlag_ff <= nxt_porFlag;
         brownoutFlag_ff <= nxt_brownoutFlag;
         prdata_ff <= nxt_prdata;
         tripSel_ff <= nxt_tripSel;
         detectOn_ff <= nxt_detectOn;
      end
   end

   assign prdata = prdata_ff;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !isMapped(paddr);
   assign brownoutTripVoltage = tripSel_ff;
   assign brownoutDetectOn = detectOn_ff;
   assign internalReset = internalReset_ff;
   assign clockStable = clockStable_ff;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   mode_off_a: assert property ((brownoutModeSelect == BROWNOUT_OFF) &&
      (state_ff != sBrownout) |=> (state_ff != sBrownout)) else $error("brown-out while off");
   brownout_hold_a: assert property ((state_ff == sBrownout) && brownoutEnabled &&
      belowSync && !porLevel |=> (state_ff == sBrownout) ##1 internalReset_ff)
      else $error("brown-out left while supply low");
   powerup_after_a: assert property ((state_ff == sBrownout) && !brownoutTrip &&
      !porLevel && !powerupTimerOff_n |=> (state_ff == sPowerup)) else $error("delay not run");
   powerup_restart_a: assert property ((state_ff == sPowerup) && brownoutTrip &&
      !porLevel |=> (state_ff == sBrownout) ##1 !powerupIf.done) else $error("not restarted");
   soft_read_a: assert property (psel && penable && !pwrite &&
      (paddr == RESET_CONTROL_OFFSET) && (brownoutModeSelect != BROWNOUT_SOFT) &&
      $stable(brownoutModeSelect) |-> !prdata[SOFT_BROWNOUT_BIT]) else $error("enable visible");
   trip_level_a: assert property ($stable(brownoutThresholdSelect)
      |=> (brownoutTripVoltage == $past(brownoutThresholdSelect)))
      else $error("trip level not from configuration");
   flag_clear_a: assert property (brownoutTrip |=> !brownoutFlag_ff)
      else $error("brown-out flag not cleared");
   powerup_skip_a: assert property ((state_ff == sPowerOn) && !porLevel &&
      powerupTimerOff_n |=> (state_ff != sPowerup)) else $error("power-up delay not skipped");
   startup_only_a: assert property ((state_ff == sOscStart) &&
      ($past(state_ff) != sOscStart) |-> crystalMode) else $error("start-up in wrong mode");
   pll_follow_a: assert property ((state_ff == sOscStart) && startupIf.done && pllOn
      && !porLevel && !brownoutTrip |=> (state_ff == sPllLock)) else $error("no PLL delay");
   por_flag_a: assert property (porLevel |=> !porFlag_ff ##0 (state_ff == sPowerOn))
      else $error("power-on flag not cleared");
   reset_timing_a: assert property ((state_ff != sRun) && !wake_ff |=> internalReset_ff)
      else $error("reset released during delay");
   pin_release_a: assert property (((state_ff == sRun) && !pinLow)[*2]
      |-> !internalReset_ff) else $error("reset held after pin release");
endmodule
`default_nettype wire

// >>> reset_timers_pkg.sv
// Shared constants and types for the brown-out and reset timer block
package reset_timers_pkg;
   localparam int CLOCK_PERIOD_NS = 20;
   // Shortest low-supply time that counts as a brown-out
   localparam int BROWNOUT_MIN_NS = 200;
   localparam int BROWNOUT_MIN_CYCLES = (BROWNOUT_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   // Nominal power-up delay: 2048 internal RC periods of about 32 us
   localparam int POWERUP_DELAY_US = 65500;
   localparam int POWERUP_TICKS = 2048;
   localparam int POWERUP_WIDTH = 11;
   localparam int STARTUP_TICKS = 1024;
   localparam int STARTUP_WIDTH = 10;
   localparam int PLL_LOCK_MS = 2;
   localparam int PLL_LOCK_CYCLES = PLL_LOCK_MS * 1000000 / CLOCK_PERIOD_NS;
   localparam int PLL_WIDTH = 17;
   localparam int ADDR_W = 12;
   localparam logic [11:0] RESET_CONTROL_OFFSET = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam int SOFT_BROWNOUT_BIT = 6;
   localparam int POWERON_FLAG_BIT = 1;
   localparam int BROWNOUT_FLAG_BIT = 0;
   localparam int STATUS_RESET_BIT = 0;
   localparam int STATUS_DETECT_BIT = 1;
   localparam int STATUS_POWERUP_BIT = 2;
   localparam int STATUS_STARTUP_BIT = 3;
   localparam int STATUS_PLL_BIT = 4;
   localparam int STATUS_STABLE_BIT = 5;
   localparam logic SOFT_BROWNOUT_RESET = 1'b1;
   localparam logic POWERON_FLAG_RESET = 1'b0;
   localparam logic BROWNOUT_FLAG_RESET = 1'b0;
   localparam logic [1:0] BROWNOUT_OFF = 2'h0;
   localparam logic [1:0] BROWNOUT_SOFT = 2'h1;
   localparam logic [1:0] BROWNOUT_AWAKE = 2'h2;
   localparam logic [1:0] BROWNOUT_ALWAYS = 2'h3;
   localparam logic [1:0] OSC_RC = 2'h0;
   localparam logic [1:0] OSC_EXTERNAL = 2'h1;
   localparam logic [1:0] OSC_CRYSTAL = 2'h2;
   localparam logic [1:0] OSC_FAST_CRYSTAL = 2'h3;
   typedef enum logic [2:0] {sPowerOn, sBrownout, sPowerup, sOscStart, sPllLock, sRun} seq_state_t;
endpackage

// >>> timer_if.sv
// Control and status bundle between the sequencer and one delay timer
`timescale 1ns/1ns
`default_nettype none
interface timer_if #(parameter int W = 11);
   logic clear;
   logic run;
   logic tick;
   logic [W-1:0] lastCount;
   logic done;
   logic busy;
   modport counter (input clear, input run, input tick, input lastCount, output done, output busy);
   modport owner (output clear, output run, output tick, output lastCount, input done, input busy);
endinterface
`default_nettype wire

// >>> input_sync.sv
// Two-flop synchroniser for a vector of asynchronous inputs with rise detect
`timescale 1ns/1ns
`default_nettype none
module input_sync #(parameter int N = 5)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [N-1:0] async,
   output logic [N-1:0] level,
   output logic [N-1:0] rise
);
   logic [N-1:0] stage1_ff, stage2_ff, stage3_ff;
   logic [N-1:0] nxt_stage1, nxt_stage2, nxt_stage3;

   always_comb
   begin
      nxt_stage1 = async;
      nxt_stage2 = stage1_ff;
      nxt_stage3 = stage2_ff;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stage1_ff <= '0;
         stage2_ff <= '0;
         stage3_ff <= '0;
      end
      else
      begin
         stage1_ff <= nxt_stage1;
         stage2_ff <= nxt_stage2;
         stage3_ff <= nxt_stage3;
      end
   end

   // Only the second and third stages feed logic
   assign level = stage2_ff;
   assign rise = stage2_ff & ~stage3_ff;
endmodule
`default_nettype wire

// >>> tick_timer.sv
// Delay timer that counts tick pulses up to a terminal count
`timescale 1ns/1ns
`default_nettype none
module tick_timer #(parameter int W = 11)
(
   input wire logic clock,
   input wire logic reset_n,
   timer_if.counter tmr
);
   logic [W-1:0] count_ff, nxt_count;
   logic done_ff, nxt_done;

   always_comb
   begin
      nxt_count = count_ff;
      nxt_done = done_ff;
      if (tmr.clear)
      begin
         nxt_count = '0;
         nxt_done = 1'b0;
      end
      else if (tmr.run && !done_ff && tmr.tick)
      begin
         if (count_ff == tmr.lastCount)
            nxt_done = 1'b1;
         else
            nxt_count = W'(count_ff + 1'b1);
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_ff <= '0;
         done_ff <= 1'b0;
      end
      else
      begin
         count_ff <= nxt_count;
         done_ff <= nxt_done;
      end
   end

   assign tmr.done = done_ff;
   assign tmr.busy = tmr.run && !done_ff;
endmodule
`default_nettype wire

// >>> supply_partner.sv
// Model of the slow RC clock and the crystal oscillator that feed the block
`timescale 1ns/1ns
`default_nettype none
module supply_partner
(
   input wire logic clock,
   output logic rcClock,
   output logic oscOut
);
   logic [2:0] rcCnt = 3'h0;
   logic [2:0] oscCnt = 3'h0;
   always @(posedge clock)
   begin
      rcCnt <= rcCnt + 3'h1;
      oscCnt <= (oscCnt == 3'h5) ? 3'h0 : oscCnt + 3'h1;
   end
   // RC period of 8 clocks keeps the 2048-tick delay short in simulation
   assign rcClock = rcCnt[2];
   // Oscillator well below clock/2 so no rising edge is lost in the synchroniser
   assign oscOut = (oscCnt < 3'h3);
endmodule
`default_nettype wire

// >>> brownout_and_reset_timers_tb_top.sv
// Self-checking testbench for the brown-out and reset timer block
`timescale 1ns/1ns
`default_nettype none
module brownout_and_reset_timers_tb_top;
   import reset_timers_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic supplyBelowTrip = 1'b0;
   logic powerOnPulse = 1'b1;
   logic pinN = 1'b1;
   logic rcClock;
   logic oscIn;
   logic sleepMode = 1'b0;
   logic wake = 1'b0;
   logic [1:0] bMode = 2'h3;
   logic [1:0] bThresh = 2'h0;
   logic pwrtN = 1'b1;
   logic [1:0] oscMode = OSC_RC;
   logic pllOn = 1'b0;
   logic [1:0] tripV;
   logic detectOn;
   logic internalReset;
   logic clockStable;
   int errors = 0;
   int nTests = 0;
   int cycles = 0;
   logic [31:0] q;
   logic e;

   always #10 clock = ~clock;

   supply_partner partner (.clock(clock), .rcClock(rcClock), .oscOut(oscIn));

   brownout_and_reset_timers #(.PllLockCycles(20)) uut (.clock(clock), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .supplyBelowTrip(supplyBelowTrip),
      .powerOnPulse(powerOnPulse), .externalResetPin_n(pinN), .internalRcClock(rcClock),
      .oscillatorInput(oscIn), .sleepMode(sleepMode), .wakeFromManaged(wake),
      .brownoutModeSelect(bMode), .brownoutThresholdSelect(bThresh),
      .powerupTimerOff_n(pwrtN), .oscMode(oscMode), .pllEnable(pllOn),
      .brownoutTripVoltage(tripV), .brownoutDetectOn(detectOn),
      .internalReset(internalReset), .clockStable(clockStable));

   task automatic stopTest();
      $display("checks %0d mismatches %0d", nTests, errors);
      if (errors == 0 && nTests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         errors++;
         stopTest();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      nTests++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // Only the bench timeout ends a stalled access
      do
      begin
         @(posedge clock);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic waitLvl(input logic lvl, input int max);
      int k;
      k = 0;
      @(negedge clock);
      while (internalReset !== lvl && k < max)
      begin
         @(negedge clock);
         k++;
      end
      check("reset level", 32'(lvl), 32'(internalReset));
      // Return on a rising edge so the next stimulus lands there
      @(posedge clock);
   endtask

   task automatic holdLvl(input int n, input logic lvl);
      int bad;
      bad = 0;
      repeat (n)
      begin
         @(negedge clock);
         if (internalReset !== lvl)
            bad++;
      end
      check("reset steady", 32'h0, 32'(bad));
      @(posedge clock);
   endtask

   task automatic powerOn(input logic [1:0] osc, input logic pll);
      @(posedge clock);
      oscMode <= osc;
      pllOn <= pll;
      powerOnPulse <= 1'b1;
      repeat (4) @(posedge clock);
      powerOnPulse <= 1'b0;
   endtask

   task automatic testRcStart();
      powerOn(OSC_RC, 1'b0);
      waitLvl(1'b0, 12);
      apb(1'b0, 12'h000, 32'h0);
      check("control", 32'h0, q);
      apb(1'b0, 12'h004, 32'h0);
      check("status", 32'h22, q);
      apb(1'b0, 12'h008, 32'h0);
      check("unmapped err", 32'h1, 32'(e));
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clock);
         bThresh <= 2'(i);
         repeat (3) @(negedge clock);
         check("trip level", 32'(i), 32'(tripV));
      end
      $display("rc start test done");
   endtask

   task automatic testModes();
      logic x;
      for (int m = 0; m < 4; m++)
         for (int s = 0; s < 2; s++)
         begin
            @(posedge clock);
            bMode <= 2'(m);
            sleepMode <= s[0];
            x = (m == 0) ? 1'b0 : (m == 2) ? !s[0] : 1'b1;
            repeat (4) @(negedge clock);
            check("detect on", 32'(x), 32'(detectOn));
         end
      @(posedge clock);
      sleepMode <= 1'b0;
      bMode <= BROWNOUT_SOFT;
      apb(1'b0, 12'h000, 32'h0);
      check("soft enable", 32'h40, q);
      apb(1'b1, 12'h000, 32'h0);
      supplyBelowTrip <= 1'b1;
      holdLvl(30, 1'b0);
      supplyBelowTrip <= 1'b0;
      apb(1'b1, 12'h000, 32'h40);
      bMode <= BROWNOUT_OFF;
      apb(1'b0, 12'h000, 32'h0);
      check("soft enable off mode", 32'h0, q);
      $display("mode test done");
   endtask

   task automatic testBrownout();
      @(posedge clock);
      bMode <= BROWNOUT_ALWAYS;
      pwrtN <= 1'b0;
      apb(1'b1, 12'h000, 32'h3);
      supplyBelowTrip <= 1'b1;
      waitLvl(1'b1, 20);
      holdLvl(40, 1'b1);
      supplyBelowTrip <= 1'b0;
      holdLvl(8000, 1'b1);
      supplyBelowTrip <= 1'b1;
      holdLvl(30, 1'b1);
      supplyBelowTrip <= 1'b0;
      holdLvl(16000, 1'b1);
      waitLvl(1'b0, 800);
      apb(1'b0, 12'h000, 32'h0);
      check("flags after brownout", 32'h2, q);
      pwrtN <= 1'b1;
      $display("brownout test done");
   endtask

   task automatic testStartup();
      powerOn(OSC_CRYSTAL, 1'b1);
      holdLvl(6000, 1'b1);
      waitLvl(1'b0, 500);
      apb(1'b0, 12'h000, 32'h0);
      check("flags after power on", 32'h0, q);
      powerOn(OSC_EXTERNAL, 1'b0);
      waitLvl(1'b0, 12);
      pinN <= 1'b0;
      powerOn(OSC_CRYSTAL, 1'b0);
      holdLvl(7000, 1'b1);
      pinN <= 1'b1;
      waitLvl(1'b0, 5);
      // Wake restart reruns the start-up timer without resetting the core
      wake <= 1'b1;
      @(posedge clock);
      wake <= 1'b0;
      holdLvl(100, 1'b0);
      check("stable during wake", 32'h0, 32'(clockStable));
      repeat (6200) @(posedge clock);
      check("stable after wake", 32'h1, 32'(clockStable));
      $display("startup test done");
   endtask

   initial
   begin
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      testRcStart();
      testModes();
      testBrownout();
      testStartup();
      stopTest();
   end
endmodule
`default_nettype wire
